/* rtl/indirect_mmr_address_gen.sv */
// Purpose: Indirect address generation for memory-mapped register operands
// Assumes: One request per cycle when not busy; accepted requests answer in 1 or 2 cycles
// Notes: Double access issues first then second address on consecutive cycles
`timescale 1ns/1ns
`default_nettype none
module indirect_mmr_address_gen
  import mmr_agen_pkg::*;
(
  input wire logic clk, // Core clock, 50 MHz
  input wire logic rst_n, // Async reset, active low
  input wire logic reqValid, // Operand request, one cycle
  input wire logic [SEL_W:0] reqSel, // 0..7 aux pointer, 8 coefficient pointer
  input wire logic [3:0] reqOp, // Operand code
  input wire logic reqDouble, // 1 for 32-bit access
  input wire logic [PTR_W-1:0] reqConst, // K16 or short k3 constant
  input wire logic [PTR_W-1:0] tempIndexFirst, // First temporary register
  input wire logic [PTR_W-1:0] tempIndexSecond, // Second temporary register
  input wire logic [PTR_W-1:0] bufferStartOffset, // Start offset for this pointer
  input wire logic [8:0] circularEnable, // Circular flags from status register two
  input wire logic legacyCompatMode, // Picks aux pointer zero as index
  input wire logic pointerModeSelect, // Control mode when 1
  input wire logic loadEn, // Pointer load strobe
  input wire logic [SEL_W:0] loadSel, // Pointer to load
  input wire logic [PTR_W-1:0] loadPtr, // Load value, low part
  input wire logic [HIGH_W-1:0] loadHigh, // Load value, high part
  output logic addrValid, // Address strobe
  output logic [ADDR_W-1:0] addr, // Data-space address
  output logic addrSecond, // 1 for second word of a pair
  output logic opRejected, // Operand refused, one cycle
  output logic busy // Second word pending
);
  mmr_agen_if link();
  phase_type phase, next_phase;
  logic [ADDR_W-1:0] pendAddr, next_pendAddr;
  logic next_addrValid, next_addrSecond, next_opRejected;
  logic [ADDR_W-1:0] next_addr;
  logic [PTR_W-1:0] step, index, effPtr, newPtr, circAdd;
  logic allowed, writeBack;

  mmr_pointer_file ptrFile (
    .clk(clk),
    .rst_n(rst_n),
    .loadEn(loadEn),
    .loadSel(loadSel),
    .loadPtr(loadPtr),
    .loadHigh(loadHigh),
    .bus(link)
  );

  // Reverse carry add for bit-reverse operands
  function automatic logic [PTR_W-1:0] revAdd(input logic [PTR_W-1:0] a,
                                              input logic [PTR_W-1:0] b);
    logic [PTR_W-1:0] ra, rb, s;
    ra = {<<{a}};
    rb = {<<{b}};
    s = ra + rb;
    return {<<{s}};
  endfunction

  // Reverse carry subtract; negating first would not mirror the borrow chain
  function automatic logic [PTR_W-1:0] revSub(input logic [PTR_W-1:0] a,
                                              input logic [PTR_W-1:0] b);
    logic [PTR_W-1:0] ra, rb, s;
    ra = {<<{a}};
    rb = {<<{b}};
    s = ra - rb;
    return {<<{s}};
  endfunction

  // Operand legality for pointer kind and mode
  function automatic logic legal(input operand_type op, input logic isCoef,
                                 input logic ctrlMode);
    logic ok;
    ok = 1'b0;
    if (isCoef) begin
      ok = op inside {OP_PLAIN, OP_POST_INC, OP_POST_DEC, OP_BASE_K16, OP_PRE_ADD_K16};
    end else if (op inside {OP_PRE_INC, OP_PRE_DEC, OP_BITREV_ADD, OP_BITREV_SUB,
                            OP_POST_ADD_T1, OP_POST_SUB_T1, OP_BASE_T1}) begin
      ok = !ctrlMode;
    end else if (op == OP_SHORT_K3) begin
      ok = ctrlMode;
    end else begin
      ok = 1'b1;
    end
    return ok;
  endfunction

  assign link.readSel = reqSel;

  // Address and pointer update computation
  always_comb begin
    operand_type op;
    op = operand_type'(reqOp);
    step = reqDouble ? STEP_DWORD : STEP_WORD;
    index = legacyCompatMode ? link.auxZero : tempIndexFirst;
    if (op inside {OP_POST_ADD_T1, OP_POST_SUB_T1, OP_BASE_T1}) begin
      index = tempIndexSecond;
    end
    allowed = legal(op, reqSel[SEL_W], pointerModeSelect);
    circAdd = circularEnable[reqSel] ? bufferStartOffset : '0;
    effPtr = link.readPtr;
    newPtr = link.readPtr;
    writeBack = 1'b0;
    case (op)
      OP_PLAIN: begin
        writeBack = 1'b0;
      end
      OP_POST_INC: begin
        newPtr = link.readPtr + step;
        writeBack = 1'b1;
      end
      OP_POST_DEC: begin
        newPtr = link.readPtr - step;
        writeBack = 1'b1;
      end
      OP_PRE_INC: begin
        newPtr = link.readPtr + step;
        effPtr = newPtr;
        writeBack = 1'b1;
      end
      OP_PRE_DEC: begin
        newPtr = link.readPtr - step;
        effPtr = newPtr;
        writeBack = 1'b1;
      end
      OP_POST_ADD_IDX, OP_POST_ADD_T1: begin
        newPtr = link.readPtr + index;
        writeBack = 1'b1;
      end
      OP_POST_SUB_IDX, OP_POST_SUB_T1: begin
        newPtr = link.readPtr - index;
        writeBack = 1'b1;
      end
      OP_BASE_IDX, OP_BASE_T1: begin
        effPtr = link.readPtr + index;
      end
      OP_BASE_K16, OP_SHORT_K3: begin
        effPtr = link.readPtr + reqConst;
      end
      OP_PRE_ADD_K16: begin
        newPtr = link.readPtr + reqConst;
        effPtr = newPtr;
        writeBack = 1'b1;
      end
      OP_BITREV_ADD: begin
        newPtr = revAdd(link.readPtr, index);
        writeBack = !circularEnable[reqSel]; // Circular pointer stays put
      end
      OP_BITREV_SUB: begin
        newPtr = revSub(link.readPtr, index);
        writeBack = !circularEnable[reqSel];
      end
      default: begin
        writeBack = 1'b0;
      end
    endcase
    link.writeEn = reqValid && (phase == ST_IDLE) && allowed && writeBack;
    link.writePtr = newPtr;
  end

  // Sequencing of single and paired addresses
  always_comb begin
    logic [ADDR_W-1:0] first;
    first = {link.readHigh, PTR_W'(effPtr + circAdd)};
    next_phase = phase;
    next_pendAddr = pendAddr;
    next_addrValid = 1'b0;
    next_addrSecond = 1'b0;
    next_opRejected = 1'b0;
    next_addr = addr;
    case (phase)
      ST_IDLE: begin
        if (reqValid && !allowed) begin
          next_opRejected = 1'b1;
        end else if (reqValid) begin
          next_addrValid = 1'b1;
          next_addr = first;
          if (reqDouble) begin
            next_pendAddr = first[0] ? first - 23'h000001 : first + 23'h000001;
            next_phase = ST_SECOND;
          end
        end
      end
      ST_SECOND: begin
        next_addrValid = 1'b1;
        next_addrSecond = 1'b1;
        next_addr = pendAddr;
        next_phase = ST_IDLE;
      end
      default: next_phase = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      phase <= ST_IDLE;
      pendAddr <= '0;
      addr <= '0;
      addrValid <= 1'b0;
      addrSecond <= 1'b0;
      opRejected <= 1'b0;
    end else begin
      phase <= next_phase;
      pendAddr <= next_pendAddr;
      addr <= next_addr;
      addrValid <= next_addrValid;
      addrSecond <= next_addrSecond;
      opRejected <= next_opRejected;
    end
  end

  // Busy marks the cycle the second word is issued from
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      busy <= 1'b0;
    end else begin
      busy <= (next_phase == ST_SECOND);
    end
  end
endmodule
`default_nettype wire

/* rtl/mmr_agen_if.sv */
// Purpose: Carrier between the pointer file and the address generator
// Assumes: One clock domain
// Notes: Update strobe carries a new 16-bit pointer value
`timescale 1ns/1ns
`default_nettype none
interface mmr_agen_if;
  import mmr_agen_pkg::*;
  logic [mmr_agen_pkg::SEL_W:0] readSel; // Bit 3 picks coefficient pointer
  logic [mmr_agen_pkg::PTR_W-1:0] readPtr;
  logic [mmr_agen_pkg::HIGH_W-1:0] readHigh;
  logic [mmr_agen_pkg::PTR_W-1:0] auxZero;
  logic writeEn;
  logic [mmr_agen_pkg::PTR_W-1:0] writePtr;
  modport gen (output readSel, output writeEn, output writePtr,
               input readPtr, input readHigh, input auxZero);
  modport file (input readSel, input writeEn, input writePtr,
                output readPtr, output readHigh, output auxZero);
endinterface
`default_nettype wire

/* rtl/mmr_agen_pkg.sv */
// Purpose: Shared constants and types for the indirect register address generator
// Assumes: 16-bit pointers, 7-bit pointer high parts, 23-bit data addresses
// Notes: Operand codes are local encodings of the indirect operand set
package mmr_agen_pkg;
  localparam int PTR_W = 16;
  localparam int HIGH_W = 7;
  localparam int ADDR_W = 23;
  localparam int NUM_AUX = 8;
  localparam int SEL_W = 3;
  localparam logic [PTR_W-1:0] STEP_WORD = 16'h0001;
  localparam logic [PTR_W-1:0] STEP_DWORD = 16'h0002;
  localparam logic [PTR_W-1:0] PTR_RESET = 16'h0000;
  localparam logic [HIGH_W-1:0] HIGH_RESET = 7'h00;
  localparam int CIRC_BIT_CDP = 8;

  typedef enum logic [3:0] {
    OP_PLAIN, OP_POST_INC, OP_POST_DEC, OP_PRE_INC, OP_PRE_DEC,
    OP_POST_ADD_IDX, OP_POST_SUB_IDX, OP_BASE_IDX,
    OP_POST_ADD_T1, OP_POST_SUB_T1, OP_BASE_T1,
    OP_BASE_K16, OP_PRE_ADD_K16, OP_SHORT_K3, OP_BITREV_ADD, OP_BITREV_SUB
  } operand_type;

  typedef enum logic {ST_IDLE, ST_SECOND} phase_type;
endpackage

/* rtl/mmr_pointer_file.sv */
// Purpose: Auxiliary and coefficient pointer storage
// Assumes: High parts loaded separately, never touched by modification
// Notes: Index 8 on the select is the coefficient pointer
`timescale 1ns/1ns
`default_nettype none
module mmr_pointer_file
  import mmr_agen_pkg::*;
(
  input wire logic clk, // Core clock
  input wire logic rst_n, // Async reset, active low
  input wire logic loadEn, // Software load of a pointer
  input wire logic [SEL_W:0] loadSel, // Which pointer to load
  input wire logic [PTR_W-1:0] loadPtr, // Low 16 bits
  input wire logic [HIGH_W-1:0] loadHigh, // High part
  mmr_agen_if.file bus // Generator side
);
  logic [PTR_W-1:0] ptr [NUM_AUX+1];
  logic [HIGH_W-1:0] high [NUM_AUX+1];
  logic [PTR_W-1:0] next_ptr [NUM_AUX+1];
  logic [HIGH_W-1:0] next_high [NUM_AUX+1];

  // Load wins over update when both hit the same pointer in one cycle
  always_comb begin
    for (int i = 0; i <= NUM_AUX; i++) begin
      next_ptr[i] = ptr[i];
      next_high[i] = high[i];
      if (loadEn && (int'(loadSel) == i)) begin
        next_ptr[i] = loadPtr;
        next_high[i] = loadHigh;
      end else if (bus.writeEn && (int'(bus.readSel) == i)) begin
        next_ptr[i] = bus.writePtr;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i <= NUM_AUX; i++) begin
        ptr[i] <= PTR_RESET;
        high[i] <= HIGH_RESET;
      end
    end else begin
      for (int i = 0; i <= NUM_AUX; i++) begin
        ptr[i] <= next_ptr[i];
        high[i] <= next_high[i];
      end
    end
  end

  assign bus.readPtr = ptr[bus.readSel];
  assign bus.readHigh = high[bus.readSel];
  assign bus.auxZero = ptr[0];
endmodule
`default_nettype wire

/* tb/indirect_mmr_address_gen_tb.sv */
// Purpose: Self-checking bench for the indirect address generator
// Assumes: Pointer high parts loaded as 05, index registers fixed
// Notes: Each row reloads pointer six, runs one operand, reads pointer back
`timescale 1ns/1ns
`default_nettype none
module indirect_mmr_address_gen_tb;
  import mmr_agen_pkg::*;
  typedef struct packed {logic [3:0] op; logic dbl; logic leg; logic [15:0] expAddr;
    logic [15:0] expPtr;} row_type;
  logic clk = 0, rst_n = 0, reqValid = 0, reqDouble = 0, legacyCompatMode = 0;
  logic pointerModeSelect = 0, loadEn = 0, addrValid, addrSecond, opRejected, busy;
  logic rejSeen = 0;
  logic [SEL_W:0] reqSel = 0, loadSel = 0;
  logic [3:0] reqOp = 0;
  logic [PTR_W-1:0] reqConst = 0, tempIndexFirst = 16'h0010, tempIndexSecond = 16'h0030;
  logic [PTR_W-1:0] bufferStartOffset = 16'h0100, loadPtr = 0;
  logic [8:0] circularEnable = 0;
  logic [HIGH_W-1:0] loadHigh = 7'h05;
  logic [ADDR_W-1:0] addr, firstAddr, secondAddr;
  int fail_count = 0, cmp_count = 0, cyc = 0;
  row_type rows[15] = '{'{OP_PLAIN, 1'h0, 1'h0, 16'h1000, 16'h1000},
    '{OP_POST_INC, 1'h0, 1'h0, 16'h1000, 16'h1001}, '{OP_POST_INC, 1'h1, 1'h0, 16'h1000, 16'h1002},
    '{OP_POST_DEC, 1'h1, 1'h0, 16'h1000, 16'h0FFE}, '{OP_PRE_INC, 1'h0, 1'h0, 16'h1001, 16'h1001},
    '{OP_PRE_DEC, 1'h1, 1'h0, 16'h0FFE, 16'h0FFE},
    '{OP_POST_ADD_IDX, 1'h0, 1'h0, 16'h1000, 16'h1010},
    '{OP_POST_ADD_IDX, 1'h0, 1'h1, 16'h1000, 16'h1020},
    '{OP_POST_SUB_IDX, 1'h0, 1'h0, 16'h1000, 16'h0FF0},
    '{OP_BASE_IDX, 1'h1, 1'h1, 16'h1020, 16'h1000},
    '{OP_POST_ADD_T1, 1'h0, 1'h0, 16'h1000, 16'h1030},
    '{OP_POST_SUB_T1, 1'h1, 1'h0, 16'h1000, 16'h0FD0},
    '{OP_BASE_T1, 1'h0, 1'h0, 16'h1030, 16'h1000},
    '{OP_BITREV_ADD, 1'h0, 1'h0, 16'h1000, 16'h1010},
    '{OP_BITREV_SUB, 1'h0, 1'h0, 16'h1000, 16'h101F}};

  indirect_mmr_address_gen dut (.clk, .rst_n, .reqValid, .reqSel, .reqOp, .reqDouble,
    .reqConst, .tempIndexFirst, .tempIndexSecond, .bufferStartOffset, .circularEnable,
    .legacyCompatMode, .pointerModeSelect, .loadEn, .loadSel, .loadPtr, .loadHigh,
    .addrValid, .addr, .addrSecond, .opRejected, .busy);
  mmr_space_model model (.clk, .rst_n, .addrValid, .addr, .addrSecond, .firstAddr,
    .secondAddr);

  // Free-running 50 MHz clock
  always #10 clk = ~clk;

  // Cycle ceiling well above the few hundred cycles the run needs
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      fail_count++;
      test_done();
    end
  end

  task automatic check(input logic [ADDR_W-1:0] seen, input logic [ADDR_W-1:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic load(input logic [3:0] s, input logic [15:0] p);
    @(negedge clk);
    loadEn = 1;
    loadSel = s;
    loadPtr = p;
    @(negedge clk);
    loadEn = 0;
  endtask

  // One request; returns once the far-side model has latched every word
  task automatic issue(input logic [3:0] s, input logic [3:0] o, input logic d);
    @(negedge clk);
    reqValid = 1;
    reqSel = s;
    reqOp = o;
    reqDouble = d;
    @(negedge clk);
    reqValid = 0;
    rejSeen = opRejected; // Refusal stands one cycle only
    repeat (d ? 2 : 1) @(negedge clk);
  endtask

  task automatic test_done();
    $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  initial begin
    repeat (10) @(negedge clk);
    rst_n = 1;
    check({addrValid, busy, opRejected}, 23'h0);
    load(0, 16'h0020);
    foreach (rows[i]) begin
      legacyCompatMode = rows[i].leg;
      load(6, 16'h1000);
      issue(6, rows[i].op, rows[i].dbl);
      check(firstAddr, {7'h05, rows[i].expAddr});
      if (rows[i].dbl) check(secondAddr, {7'h05, rows[i].expAddr ^ 16'h0001});
      issue(6, OP_PLAIN, 0);
      check(firstAddr, {7'h05, rows[i].expPtr});
    end
    legacyCompatMode = 0;
    // Odd first address pairs downward
    load(6, 16'h1001);
    issue(6, OP_PLAIN, 1);
    check(firstAddr, {7'h05, 16'h1001});
    check(secondAddr, {7'h05, 16'h1000});
    // Wrap at the top of the 16-bit pointer, high part kept
    load(6, 16'hFFFF);
    issue(6, OP_POST_INC, 0);
    @(negedge clk);
    reqValid = 1;
    reqOp = OP_PLAIN;
    repeat (2) @(negedge clk);
    reqValid = 0;
    check(addr, {7'h05, 16'h0000});
    // Circular pointer gets its start offset
    circularEnable = 9'h040;
    load(6, 16'h1000);
    issue(6, OP_PLAIN, 0);
    check(firstAddr, {7'h05, 16'h1100});
    circularEnable = 0;
    // Control mode refuses pre-modify and leaves the pointer alone
    pointerModeSelect = 1;
    issue(6, OP_PRE_INC, 0);
    check(rejSeen, 23'h1);
    pointerModeSelect = 0;
    issue(6, OP_PLAIN, 0);
    check(firstAddr, {7'h05, 16'h1000});
    // Coefficient pointer: pre-modify refused, post-increment pair accepted
    issue(8, OP_PRE_INC, 0);
    check(rejSeen, 23'h1);
    load(8, 16'h2000);
    issue(8, OP_POST_INC, 1);
    issue(8, OP_PLAIN, 0);
    check(firstAddr, {7'h05, 16'h2002});
    // Constant offsets on an aux pointer and on the coefficient pointer
    reqConst = 16'h0009;
    load(6, 16'h1000);
    issue(6, OP_BASE_K16, 0);
    check(firstAddr, {7'h05, 16'h1009});
    issue(8, OP_PRE_ADD_K16, 0);
    check(firstAddr, {7'h05, 16'h200B});
    issue(8, OP_BASE_K16, 0);
    check(firstAddr, {7'h05, 16'h2014});
    issue(8, OP_POST_DEC, 1);
    check(firstAddr, {7'h05, 16'h200B});
    check(secondAddr, {7'h05, 16'h200A});
    // Control mode takes the short offset, refuses bit-reverse and second index
    pointerModeSelect = 1;
    reqConst = 16'h0003;
    issue(6, OP_SHORT_K3, 0);
    check(firstAddr, {7'h05, 16'h1003});
    check(rejSeen, 23'h0);
    issue(6, OP_BITREV_ADD, 0);
    check(rejSeen, 23'h1);
    issue(6, OP_BASE_T1, 0);
    check(rejSeen, 23'h1);
    pointerModeSelect = 0;
    issue(6, OP_SHORT_K3, 0);
    check(rejSeen, 23'h1);
    reqConst = 0;
    // Reset cutting a pair clears outputs and pointers
    load(6, 16'h1234);
    @(negedge clk);
    reqValid = 1;
    reqSel = 6;
    reqOp = OP_PLAIN;
    reqDouble = 1;
    @(negedge clk);
    reqValid = 0;
    check(busy, 23'h1);
    rst_n = 0;
    @(negedge clk);
    check({addrValid, busy, opRejected}, 23'h0);
    rst_n = 1;
    issue(6, OP_POST_INC, 0);
    issue(6, OP_PLAIN, 0);
    check(firstAddr, 23'h000001);
    test_done();
  end
endmodule
`default_nettype wire

/* tb/mmr_agen_monitor.sv */
// Purpose: Port-level checks on the indirect address generator
// Assumes: Single clock domain, async active-low reset
// Notes: Opcode checks use the package encoding
`timescale 1ns/1ns
`default_nettype none
module mmr_agen_monitor
  import mmr_agen_pkg::*;
(
  input wire logic clk, // Core clock
  input wire logic rst_n, // Async reset
  input wire logic reqValid, // Request strobe
  input wire logic [SEL_W:0] reqSel, // Pointer select
  input wire logic [3:0] reqOp, // Operand code
  input wire logic reqDouble, // Pair access
  input wire logic pointerModeSelect, // Control mode
  input wire logic loadEn, // Pointer load
  input wire logic [8:0] circularEnable, // Circular flags
  input wire logic addrValid, // Address strobe
  input wire logic [ADDR_W-1:0] addr, // Address
  input wire logic addrSecond, // Second word
  input wire logic opRejected, // Refusal pulse
  input wire logic busy // Pair pending
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  // Two plain reads in a row with nothing loaded in between
  sequence plainPair;
    (reqValid && !busy && reqOp == OP_PLAIN && !reqDouble && !loadEn) ##1
    (reqValid && reqOp == OP_PLAIN && !reqDouble && !loadEn && $stable(reqSel)
     && $stable(circularEnable));
  endsequence
  a_single_answer: assert property (reqValid && !busy |=> addrValid != opRejected)
    else $error("taken request gave no single answer");
  a_pair_follows: assert property (busy |=> addrValid && addrSecond && !busy)
    else $error("second word missing after busy");
  a_second_adjacent: assert property (addrValid && addrSecond |->
    addr == {$past(addr[ADDR_W-1:1]), ~$past(addr[0]), 1'h0} >> 1)
    else $error("second address not adjacent");
  a_reject_quiet: assert property (opRejected |-> !addrValid && !busy)
    else $error("refused operand produced an address");
  a_mode_reject: assert property (reqValid && !busy && pointerModeSelect && reqSel < 4'h8
    && reqOp == OP_PRE_INC |=> opRejected)
    else $error("pre-modify accepted in control mode");
  a_mode_accept: assert property (reqValid && !busy && !pointerModeSelect && reqSel < 4'h8
    && reqOp inside {OP_PRE_INC, OP_PRE_DEC} |=> addrValid && !opRejected)
    else $error("pre-modify refused in DSP mode");
  a_coef_reject: assert property (reqValid && !busy && reqSel == 4'h8
    && reqOp == OP_PRE_INC |=> opRejected)
    else $error("coefficient pointer took a pre-modify");
  a_plain_keeps: assert property (plainPair |=> addr == $past(addr))
    else $error("plain operand moved the pointer");
  c_pair: cover property (busy ##1 addrSecond);
  c_reject: cover property (opRejected);
  c_plain_pair: cover property (plainPair);
endmodule
`default_nettype wire
bind indirect_mmr_address_gen mmr_agen_monitor mon (.clk, .rst_n, .reqValid, .reqSel,
  .reqOp, .reqDouble, .pointerModeSelect, .loadEn, .circularEnable, .addrValid, .addr,
  .addrSecond, .opRejected, .busy);

/* tb/mmr_space_model.sv */
// Purpose: Far-side model of the register data space fed by the generator
// Assumes: First word strobe precedes its partner by one cycle
// Notes: Keeps only the addresses each destination register would be fed from
`timescale 1ns/1ns
`default_nettype none
module mmr_space_model
  import mmr_agen_pkg::*;
(
  input wire logic clk, // Core clock
  input wire logic rst_n, // Async reset, active low
  input wire logic addrValid, // Address strobe
  input wire logic [ADDR_W-1:0] addr, // Data-space address
  input wire logic addrSecond, // Second word of a pair
  output logic [ADDR_W-1:0] firstAddr, // Source of first destination register
  output logic [ADDR_W-1:0] secondAddr // Source of second destination register
);
  // Route each word by its order, not its address, so pairing faults show
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      firstAddr <= '0;
      secondAddr <= '0;
    end else if (addrValid && !addrSecond) begin
      firstAddr <= addr;
    end else if (addrValid) begin
      secondAddr <= addr;
    end
  end
endmodule
`default_nettype wire
